/* control_flow_instruction_decoder.sv */
// Local design decisions: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "cfd_defs.svh"
module control_flow_instruction_decoder (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // port pins
   input  wire logic [7:0]  port_pins,
   output logic      [7:0]  port_out,
   // status
   output logic             sleeping,
   output logic             table_write_busy
);
   import cfd_pkg::*;

   st_t         q;
   st_t         d;
   logic        mem_we;
   logic [11:0] mem_addr;
   logic [7:0]  mem_wdata;
   logic [7:0]  mem_rdata;
   logic        take;
   logic        need2;
   logic [11:0] ea;
   logic [7:0]  src;
   logic [2:0]  top;
   logic        bus_wr;
   logic        idle;
   logic        wr_first;

   // effective data address of a register operand
   function automatic logic [11:0] eff_addr(input logic [15:0] w, input logic [7:0] bank_select_register);
      logic [11:0] r;
      r = w[8] ? {bank_select_register[3:0], w[7:0]} : {(w[7] ? `ACC_HI : 4'h0), w[7:0]};
      return r;
   endfunction : eff_addr

   data_memory u_mem (
      .clk   (hclk),
      .we    (mem_we),
      .addr  (mem_addr),
      .wdata (mem_wdata),
      .rdata (mem_rdata)
   );

   assign hreadyout        = 1'b1;
   assign hresp            = 1'b0;
   assign port_out         = q.latch;
   assign sleeping         = q.sleeping;
   assign table_write_busy = q.twr_busy;
   assign idle             = (q.phase == PH_IDLE);
   assign bus_wr           = q.aph_v & q.aph_w;
   assign ea               = eff_addr(q.iw, q.bank_select_register);
   assign top              = 3'(q.sp - 4'd1);
   assign wr_first         = (q.phase == PH_WRITE) & ~q.second;

   // branch test chosen by the low three bits of the upper byte
   always_comb begin
      case (q.iw[10:8])
         3'd0:    take = q.fl[`FL_Z];
         3'd1:    take = ~q.fl[`FL_Z];
         3'd2:    take = q.fl[`FL_C];
         3'd3:    take = ~q.fl[`FL_C];
         3'd4:    take = q.fl[`FL_OV];
         3'd5:    take = ~q.fl[`FL_OV];
         3'd6:    take = q.fl[`FL_N];
         default: take = ~q.fl[`FL_N];
      endcase
   end

   assign need2 = ((q.op == OP_BCOND) & take) | (q.op == OP_INTERRUPT_RETURN) |
                  (q.op == OP_RETURN) | (q.op == OP_LITERAL_RETURN);

   // operand source: pins for the port, never the latch
   always_comb begin
      if (ea == `DA_PORT) src = q.sync2;
      else if (ea == `DA_TIMER_ZERO) src = q.timer_zero;
      else src = mem_rdata;
   end

   // memory belongs to the sequencer while an instruction runs
   always_comb begin
      mem_addr  = idle ? q.maddr : ea;
      mem_wdata = idle ? hwdata[7:0] : q.res;
      mem_we    = 1'b0;
      if (idle) mem_we = bus_wr & (q.aph_a == `RA_MDATA);
      else if (q.phase == PH_WRITE && !q.second && q.op == OP_NEGATE_REGISTER &&
               ea != `DA_PORT && ea != `DA_TIMER_ZERO) mem_we = 1'b1;
   end

   always_comb begin
      if (q.aph_a == `RA_INSTR) hrdata = {16'h0000, q.iw};
      else if (q.aph_a == `RA_STATUS)
         hrdata = {16'h0000, q.twr_busy, q.sleeping, q.pend, ~idle, q.peie, q.gie,
                   q.pd, q.to, 3'b000, q.fl};
      else if (q.aph_a == `RA_WORKING_REGISTER) hrdata = {24'h000000, q.working_register};
      else if (q.aph_a == `RA_BSR) hrdata = {24'h000000, q.bank_select_register};
      else if (q.aph_a == `RA_PC) hrdata = {12'h000, q.pc};
      else if (q.aph_a == `RA_STACK)
         hrdata = {8'h00, q.sp, (q.sp == 4'd0) ? 20'h00000 : q.stk[top]};
      else if (q.aph_a == `RA_CTRL) hrdata = {28'h0000000, q.peie, q.gie, q.twr_busy, q.psa};
      else if (q.aph_a == `RA_TIMER) hrdata = {16'h0000, q.pre, q.timer_zero};
      else if (q.aph_a == `RA_LATCH) hrdata = {24'h000000, q.latch};
      else if (q.aph_a == `RA_CYCLES) hrdata = {30'h00000000, q.cycles};
      else if (q.aph_a == `RA_MADDR) hrdata = {20'h00000, q.maddr};
      else if (q.aph_a == `RA_MDATA) hrdata = {24'h000000, mem_rdata};
      else hrdata = 32'h00000000;
   end

   always_comb begin
      d = q;
      d.sync1 = port_pins;
      d.sync2 = q.sync1;
      // address phase capture
      d.aph_v = hsel & htrans[1] & hready;
      d.aph_w = hwrite;
      d.aph_a = {haddr[7:2], 2'b00};
      // timer runs from the prescaler when assigned
      if (q.psa) begin
         d.pre = q.pre + 8'd1;
         if (q.pre == 8'hFF) d.timer_zero = q.timer_zero + 8'd1;
      end else begin
         d.timer_zero = q.timer_zero + 8'd1;
      end
      // table write counts down to its end; nothing stops it early
      if (q.twr_busy) begin
         d.twr_cnt = q.twr_cnt - 8'd1;
         if (q.twr_cnt == 8'd0) d.twr_busy = 1'b0;
      end
      if (bus_wr && q.aph_a == `RA_CTRL) begin
         d.psa  = hwdata[`CT_PSA];
         d.gie  = hwdata[`CT_GIE];
         d.peie = hwdata[`CT_PEIE];
         if (hwdata[`CT_TWR] && !q.twr_busy) begin
            d.twr_busy = 1'b1;
            d.twr_cnt  = `TWR_CLKS - 8'd1;
         end
      end
      // register writes other than the control register only while the sequencer rests
      if (bus_wr && idle) begin
         if (q.aph_a == `RA_INSTR) begin
            d.iw       = hwdata[15:0];
            d.phase    = PH_DEC;
            d.second   = 1'b0;
            d.sleeping = 1'b0;
         end else if (q.aph_a == `RA_WORKING_REGISTER) d.working_register = hwdata[7:0];
         else if (q.aph_a == `RA_BSR) d.bank_select_register = hwdata[7:0];
         else if (q.aph_a == `RA_LATCH) d.latch = hwdata[7:0];
         else if (q.aph_a == `RA_MADDR) d.maddr = hwdata[11:0];
      end
      case (q.phase)
         PH_DEC: begin
            d.op    = q.second ? OP_NOP : decode_op(q.iw, q.pend);
            d.phase = PH_READ;
         end
         PH_READ: d.phase = PH_PROC;
         PH_PROC: begin
            d.rd    = src;
            d.res   = 8'(~src + 8'd1);
            d.phase = PH_WRITE;
         end
         PH_WRITE: begin
            if (q.second) begin
               d.phase  = PH_IDLE;
               d.cycles = 2'd2;
            end else begin
               d.phase  = need2 ? PH_DEC : PH_IDLE;
               d.second = need2;
               d.cycles = 2'd1;
               d.pend   = 1'b0;
               d.pc     = q.pc + 20'd1;
               case (q.op)
                  OP_BCOND: begin
                     if (take) d.pc = q.pc + 20'd1 + {{12{q.iw[7]}}, q.iw[7:0]};
                  end
                  OP_GOTO1, OP_CALL1: begin
                     d.pend      = 1'b1;
                     d.pend_call = (q.op == OP_CALL1);
                     d.pend_s    = q.iw[8];
                     d.lo8       = q.iw[7:0];
                  end
                  OP_LONG2: begin
                     d.pc = {q.iw[11:0], q.lo8};
                     if (q.pend_call && q.sp != 4'(`STK_DEPTH)) begin
                        d.stk[q.sp[2:0]] = q.pc + 20'd1;
                        d.sp             = q.sp + 4'd1;
                     end
                     if (q.pend_call && q.pend_s) begin
                        d.sh_w   = q.working_register;
                        d.sh_fl  = q.fl;
                        d.sh_bsr = q.bank_select_register;
                     end
                  end
                  OP_PUSH: begin
                     if (q.sp != 4'(`STK_DEPTH)) begin
                        d.stk[q.sp[2:0]] = q.pc + 20'd1;
                        d.sp             = q.sp + 4'd1;
                     end
                  end
                  OP_POP: if (q.sp != 4'd0) d.sp = q.sp - 4'd1;
                  OP_INTERRUPT_RETURN, OP_RETURN, OP_LITERAL_RETURN: begin
                     if (q.sp != 4'd0) begin
                        d.pc = q.stk[top];
                        d.sp = q.sp - 4'd1;
                     end
                     if (q.op == OP_INTERRUPT_RETURN) d.gie = 1'b1;
                     if (q.op == OP_LITERAL_RETURN) d.working_register = q.iw[7:0];
                     else if (q.iw[0]) begin
                        d.working_register = q.sh_w;
                        d.fl   = q.sh_fl;
                        d.bank_select_register  = q.sh_bsr;
                     end
                  end
                  OP_SLEEP: begin
                     d.to       = 1'b1;
                     d.pd       = 1'b0;
                     d.sleeping = 1'b1;
                  end
                  OP_WATCHDOG_CLEAR_OP: begin
                     d.to = 1'b1;
                     d.pd = 1'b1;
                  end
                  OP_NEGATE_REGISTER: begin
                     d.fl[`FL_N]  = q.res[7];
                     d.fl[`FL_Z]  = (q.res == 8'h00);
                     d.fl[`FL_C]  = (q.rd == 8'h00);
                     d.fl[`FL_DC] = (q.rd[3:0] == 4'h0);
                     d.fl[`FL_OV] = (q.rd == 8'h80);
                     if (ea == `DA_PORT) d.latch = q.res;
                     else if (ea == `DA_TIMER_ZERO) begin
                        d.timer_zero = q.res;
                        if (q.psa) d.pre = 8'h00;
                     end
                  end
                  default: ;
               endcase
            end
         end
         default: ;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q    <= '0;
         q.to <= 1'b1;
         q.pd <= 1'b1;
      end else begin
         q <= d;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_phase_order: assert property (q.phase == PH_DEC |=> q.phase == PH_READ ##1
      q.phase == PH_PROC ##1 q.phase == PH_WRITE) else $error("phase order broken");
   a_branch_fail: assert property (wr_first && q.op == OP_BCOND && !take |=>
      q.phase == PH_IDLE && q.cycles == 2'd1) else $error("failed branch not one cycle");
   a_branch_pass: assert property (wr_first && q.op == OP_BCOND && take |=>
      q.second ##3 q.phase == PH_WRITE ##1 q.phase == PH_IDLE && q.cycles == 2'd2)
      else $error("taken branch not two cycles");
   a_push_flags: assert property (wr_first && q.op == OP_PUSH && q.sp < 4'd8 |=>
      q.fl == $past(q.fl) && q.sp == $past(q.sp) + 4'd1) else $error("push wrong");
   a_pop_flags: assert property (wr_first && q.op == OP_POP && q.sp != 4'd0 |=>
      q.fl == $past(q.fl) && q.sp == $past(q.sp) - 4'd1) else $error("pop wrong");
   a_interrupt_return_gie: assert property (wr_first && q.op == OP_INTERRUPT_RETURN |=> q.gie && q.second)
      else $error("interrupt return did not enable");
   a_literal_return_working_register: assert property (wr_first && q.op == OP_LITERAL_RETURN |=>
      q.working_register == $past(q.iw[7:0])) else $error("literal not loaded");
   a_sleep_flags: assert property (wr_first && q.op == OP_SLEEP |=>
      q.to && !q.pd && q.sleeping) else $error("standby flags wrong");
   a_watchdog_clear_op_flags: assert property (wr_first && q.op == OP_WATCHDOG_CLEAR_OP |=> q.to && q.pd)
      else $error("watchdog clear flags wrong");
   a_negate_register_value: assert property (q.phase == PH_PROC && q.op == OP_NEGATE_REGISTER |=>
      q.res == 8'(8'h00 - $past(src))) else $error("negate result wrong");
   a_long_target: assert property (wr_first && q.op == OP_LONG2 |=>
      q.pc == {$past(q.iw[11:0]), $past(q.lo8)}) else $error("long jump target wrong");
   a_access_bank: assert property (!idle && !q.iw[8] |->
      mem_addr == {{4{q.iw[7]}}, q.iw[7:0]}) else $error("access bank address wrong");
   a_tmr_prescale: assert property (wr_first && q.op == OP_NEGATE_REGISTER && ea == `DA_TIMER_ZERO
      && q.psa |=> q.pre == 8'h00) else $error("prescaler not cleared");
   a_twr_hold: assert property (q.twr_busy && q.twr_cnt != 8'd0 |=> q.twr_busy)
      else $error("table write aborted");

   c_branch_taken: cover property (wr_first && q.op == OP_BCOND && take);
   c_long_call: cover property (wr_first && q.op == OP_LONG2 && q.pend_call);
   c_negate_register_port: cover property (wr_first && q.op == OP_NEGATE_REGISTER && ea == `DA_PORT);
   c_table_write: cover property (q.twr_busy && q.twr_cnt == 8'd0);
endmodule : control_flow_instruction_decoder

/* cfd_defs.svh */
`ifndef CFD_DEFS_SVH
`define CFD_DEFS_SVH

// register byte offsets
`define RA_INSTR   8'h00
`define RA_STATUS  8'h04
`define RA_WORKING_REGISTER    8'h08
`define RA_BSR     8'h0C
`define RA_PC      8'h10
`define RA_STACK   8'h14
`define RA_CTRL    8'h18
`define RA_TIMER   8'h1C
`define RA_LATCH   8'h20
`define RA_CYCLES  8'h24
`define RA_MADDR   8'h28
`define RA_MDATA   8'h2C
// control register fields
`define CT_PSA     0
`define CT_TWR     1
`define CT_GIE     2
`define CT_PEIE    3
// flag positions
`define FL_C       0
`define FL_DC      1
`define FL_Z       2
`define FL_OV      3
`define FL_N       4
// special data addresses
`define DA_PORT    12'hF80
`define DA_TIMER_ZERO    12'hFD6
`define ACC_HI     4'hF
// encodings
`define OPC_BCOND  5'b11100
`define OPC_GOTO   8'hEF
`define OPC_CALL   7'b1110110
`define OPC_LITERAL_RETURN  8'h0C
`define OPC_NEGATE_REGISTER   7'b0110110
`define OPC_SLEEP  16'h0003
`define OPC_WATCHDOG_CLEAR_OP 16'h0004
`define OPC_PUSH   16'h0005
`define OPC_POP    16'h0006
`define OPC_INTERRUPT_RETURN 15'h0008
`define OPC_RETURN 15'h0009
// sizes and timing
`define STK_DEPTH  8
`define TWR_CLKS   8'd20
`endif

/* cfd_pkg.sv */
`include "cfd_defs.svh"
package cfd_pkg;
   typedef enum logic [2:0] {
      PH_IDLE  = 3'b000,
      PH_DEC   = 3'b001,
      PH_READ  = 3'b011,
      PH_PROC  = 3'b010,
      PH_WRITE = 3'b110
   } phase_t;

   typedef enum logic [3:0] {
      OP_NOP, OP_BCOND, OP_GOTO1, OP_CALL1, OP_LONG2, OP_PUSH, OP_POP,
      OP_INTERRUPT_RETURN, OP_RETURN, OP_LITERAL_RETURN, OP_SLEEP, OP_WATCHDOG_CLEAR_OP, OP_NEGATE_REGISTER
   } op_t;

   typedef struct packed {
      phase_t                         phase;
      op_t                            op;
      logic                           second;
      logic [15:0]                    iw;
      logic                           pend;
      logic                           pend_call;
      logic                           pend_s;
      logic [7:0]                     lo8;
      logic [7:0]                     rd;
      logic [7:0]                     res;
      logic [19:0]                    pc;
      logic [7:0]                     working_register;
      logic [7:0]                     bank_select_register;
      logic [4:0]                     fl;
      logic                           to;
      logic                           pd;
      logic                           gie;
      logic                           peie;
      logic                           sleeping;
      logic [3:0]                     sp;
      logic [`STK_DEPTH-1:0][19:0]    stk;
      logic [7:0]                     sh_w;
      logic [4:0]                     sh_fl;
      logic [7:0]                     sh_bsr;
      logic                           psa;
      logic [7:0]                     timer_zero;
      logic [7:0]                     pre;
      logic [7:0]                     latch;
      logic [1:0]                     cycles;
      logic                           twr_busy;
      logic [7:0]                     twr_cnt;
      logic                           aph_v;
      logic                           aph_w;
      logic [7:0]                     aph_a;
      logic [11:0]                    maddr;
      logic [7:0]                     sync1;
      logic [7:0]                     sync2;
   } st_t;

   function automatic op_t decode_op(input logic [15:0] w, input logic pend);
      op_t o;
      o = OP_NOP;
      if (w[15:12] == 4'hF) begin
         if (pend) o = OP_LONG2;
      end else if (w[15:11] == `OPC_BCOND) o = OP_BCOND;
      else if (w[15:8] == `OPC_GOTO) o = OP_GOTO1;
      else if (w[15:9] == `OPC_CALL) o = OP_CALL1;
      else if (w[15:8] == `OPC_LITERAL_RETURN) o = OP_LITERAL_RETURN;
      else if (w[15:9] == `OPC_NEGATE_REGISTER) o = OP_NEGATE_REGISTER;
      else if (w == `OPC_PUSH) o = OP_PUSH;
      else if (w == `OPC_POP) o = OP_POP;
      else if (w == `OPC_SLEEP) o = OP_SLEEP;
      else if (w == `OPC_WATCHDOG_CLEAR_OP) o = OP_WATCHDOG_CLEAR_OP;
      else if (w[15:1] == `OPC_INTERRUPT_RETURN) o = OP_INTERRUPT_RETURN;
      else if (w[15:1] == `OPC_RETURN) o = OP_RETURN;
      return o;
   endfunction : decode_op
endpackage : cfd_pkg

/* data_memory.sv */
`timescale 1ns/1ps
module data_memory (
   // clock
   input  wire logic        clk,
   // access
   input  wire logic        we,
   input  wire logic [11:0] addr,
   input  wire logic [7:0]  wdata,
   output logic      [7:0]  rdata
);
   logic [7:0] mem [0:4095];

   // read-before-write, data registered
   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule : data_memory

/* prog_rom.sv */
`timescale 1ns/1ps
module prog_rom (
   // fetch
   input  wire logic [4:0]  addr,
   output logic      [15:0] word
);
   logic [15:0] mem [0:31];

   initial begin
      // unused words hold 1111 words, so every location is a valid instruction
      mem = '{0: 16'h0C5A, 1: 16'h6C10, 2: 16'h6D10, 3: 16'h0000, 4: 16'hE602,
              5: 16'hE702, 6: 16'hE002, 7: 16'hE102, 8: 16'h0005, 9: 16'h0006,
              10: 16'hEF34, 11: 16'hF012, 12: 16'hF555, 13: 16'hED56,
              14: 16'hF000, 15: 16'h0010, 16: 16'h0004, 17: 16'h6C80,
              18: 16'h0012, 19: 16'h0003, default: 16'hFFFF};
   end

   assign word = mem[addr];
endmodule : prog_rom

/* control_flow_instruction_decoder_tb.sv */
`timescale 1ns/1ps
module control_flow_instruction_decoder_tb;
   typedef struct {
      logic [7:0]  a;
      logic [31:0] m;
      logic [31:0] e;
      logic [31:0] c;
   } row_t;

   logic        hclk      = 1'b0;
   logic        hresetn   = 1'b0;
   logic        hsel      = 1'b0;
   logic [31:0] haddr     = 32'h0;
   logic [1:0]  htrans    = 2'b00;
   logic        hwrite    = 1'b0;
   logic [31:0] hwdata    = 32'h0;
   logic [7:0]  port_pins = 8'h0F;
   logic [4:0]  pc_idx    = 5'h0;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic [7:0]  port_out;
   logic        sleeping;
   logic        table_write_busy;
   logic [15:0] word;
   logic [31:0] rd;
   logic [31:0] cyc;
   logic [31:0] t;
   int          fail_count = 0;
   int          n_tests    = 0;
   int          twr_cnt    = 0;
   row_t        rows [20];

   always #25 hclk = ~hclk;

   always @(posedge hclk) begin
      if (table_write_busy === 1'b1) twr_cnt <= twr_cnt + 1;
   end

   control_flow_instruction_decoder u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .port_pins(port_pins),
      .port_out(port_out), .sleeping(sleeping), .table_write_busy(table_write_busy)
   );

   prog_rom u_rom (.addr(pc_idx), .word(word));

   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // entered just after a rising edge; returns at the edge ending the data phase
   task xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : xfer

   task wait_idle;
      int n;
      n = 0;
      do begin
         xfer(8'h04, 1'b0, 32'h0);
         n++;
      end while (rd[12] !== 1'b0 && n < 60);
      if (n >= 60) fail_count++;
   endtask : wait_idle

   task run(input logic [15:0] w);
      xfer(8'h00, 1'b1, {16'h0, w});
      wait_idle;
      xfer(8'h24, 1'b0, 32'h0);
      cyc = rd;
   endtask : run

   task do_reset;
      hresetn <= 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
   endtask : do_reset

   task summarize;
      $display("counts: %0d compares, %0d mismatches", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize

   initial begin
      #(20000 * 50);
      fail_count++;
      summarize;
   end

   initial begin
      rows = '{'{8'h08, 32'hFF, 32'h5A, 2}, '{8'h2C, 32'hFF, 32'hC6, 1},
               '{8'h2C, 32'hFF, 32'hC6, 1}, '{8'h04, 32'h14, 32'h10, 1},
               '{8'h04, 32'h14, 32'h10, 2}, '{8'h04, 32'h14, 32'h10, 1},
               '{8'h04, 32'h14, 32'h10, 1}, '{8'h04, 32'h14, 32'h10, 2},
               '{8'h14, 32'hF00000, 32'h100000, 1},
               '{8'h14, 32'hF00000, 32'h0, 1},
               '{8'h04, 32'h2000, 32'h2000, 1}, '{8'h10, 32'hFFFFF, 32'h1234, 1},
               '{8'h10, 32'hFFFFF, 32'h1235, 1}, '{8'h04, 32'h2000, 32'h2000, 1},
               '{8'h14, 32'hF00000, 32'h100000, 1},
               '{8'h04, 32'h400, 32'h400, 2}, '{8'h04, 32'h300, 32'h300, 1},
               '{8'h20, 32'hFF, 32'hF1, 1}, '{8'h14, 32'hF00000, 32'h0, 2},
               '{8'h04, 32'h4000, 32'h4000, 1}};
      do_reset;
      check({29'h0, sleeping, table_write_busy, hresp}, 32'h0);
      check({24'h0, port_out}, 32'h0);
      xfer(8'h04, 1'b0, 32'h0);
      check(rd, 32'h0300);
      $display("test reset done");
      // bank 2 holds 0x01 at 0x210, access bank 0x3A at 0x010
      xfer(8'h0C, 1'b1, 32'h2);
      xfer(8'h28, 1'b1, 32'h210);
      xfer(8'h2C, 1'b1, 32'h01);
      xfer(8'h28, 1'b1, 32'h010);
      xfer(8'h2C, 1'b1, 32'h3A);
      xfer(8'h20, 1'b1, 32'hFF);
      for (int i = 0; i < 20; i++) begin
         pc_idx <= i[4:0];
         @(posedge hclk);
         run(word);
         check(cyc, rows[i].c);
         xfer(rows[i].a, 1'b0, 32'h0);
         check(rd & rows[i].m, rows[i].e);
      end
      check({31'h0, sleeping}, 32'h1);
      check({24'h0, port_out}, 32'hF1);
      run(16'h0000);
      check({31'h0, sleeping}, 32'h0);
      xfer(8'h04, 1'b0, 32'h0);
      check(rd & 32'h300, 32'h100);
      run(16'h0004);
      xfer(8'h04, 1'b0, 32'h0);
      check(rd & 32'h300, 32'h300);
      xfer(8'h28, 1'b1, 32'h210);
      xfer(8'h2C, 1'b0, 32'h0);
      check(rd, 32'hFF);
      $display("test program done");
      // each condition and its opposite: exactly one of the pair is taken
      for (int k = 0; k < 4; k++) begin
         run({5'b11100, k[1:0], 1'b0, 8'h01});
         t = cyc;
         run({5'b11100, k[1:0], 1'b1, 8'h01});
         check(t + cyc, 32'h3);
      end
      $display("test branch pairs done");
      // register write while a two-cycle op is busy is dropped
      xfer(8'h00, 1'b1, 32'h0C77);
      xfer(8'h08, 1'b1, 32'h11);
      wait_idle;
      xfer(8'h08, 1'b0, 32'h0);
      check(rd, 32'h77);
      $display("test busy write done");
      xfer(8'h18, 1'b1, 32'h1);
      repeat (120) @(posedge hclk);
      run(16'h6CD6);
      xfer(8'h1C, 1'b0, 32'h0);
      check({31'h0, rd[15:8] < 8'h20}, 32'h1);
      $display("test prescaler done");
      t = twr_cnt;
      xfer(8'h18, 1'b1, 32'h3);
      repeat (8) @(posedge hclk);
      xfer(8'h18, 1'b1, 32'h3);
      repeat (40) @(posedge hclk);
      check(twr_cnt - t, 32'd20);
      check({31'h0, table_write_busy}, 32'h0);
      $display("test table write done");
      xfer(8'h40, 1'b1, 32'hFFFFFFFF);
      xfer(8'h40, 1'b0, 32'h0);
      check(rd, 32'h0);
      do_reset;
      xfer(8'h04, 1'b0, 32'h0);
      check(rd, 32'h0300);
      check({24'h0, port_out}, 32'h0);
      $display("test unmapped and second reset done");
      summarize;
   end
endmodule : control_flow_instruction_decoder_tb
